//--- pac_pkg.sv
/*
  Shared constants for the pressure acquisition control block: register
  offsets, bit positions, reset values and timing figures.
  Assumes a 25 MHz core clock; nothing else.
*/
package pac_pkg;

  // Register offsets on the serial register port
  localparam logic [6:0] ADDR_ACQ_CTRL   = 7'h10;
  localparam logic [6:0] ADDR_SYS_CTRL   = 7'h11;
  localparam logic [6:0] ADDR_OFFSET_LO  = 7'h18;
  localparam logic [6:0] ADDR_OFFSET_HI  = 7'h19;
  localparam logic [6:0] ADDR_PRESS_XL   = 7'h28;
  localparam logic [6:0] ADDR_PRESS_L    = 7'h29;
  localparam logic [6:0] ADDR_PRESS_H    = 7'h2A;
  localparam logic [6:0] ADDR_TEMP_L     = 7'h2B;
  localparam logic [6:0] ADDR_TEMP_H     = 7'h2C;
  localparam logic [6:0] ADDR_FILTER_RST = 7'h33;

  // Field positions in acquisition_control
  localparam int RATE_LSB      = 4;
  localparam int FILT_EN_BIT   = 3;
  localparam int FILT_BW_BIT   = 2;
  localparam int LOCK_BIT      = 1;
  // Field positions in system_control
  localparam int REBOOT_BIT    = 7;
  localparam int AUTOINC_BIT   = 4;
  localparam int SOFTRST_BIT   = 2;
  localparam int ONESHOT_BIT   = 0;

  // Values after reset
  localparam logic [7:0]  ACQ_CTRL_RESET = 8'h00;
  localparam logic [7:0]  SYS_CTRL_RESET = 8'h10;
  localparam logic [15:0] OFFSET_RESET   = 16'h0000;
  localparam logic [2:0]  RATE_OFF       = 3'h0;

  // Output rates and derived periods
  localparam int CLK_HZ     = 25_000_000;
  localparam int RATE1_HZ   = 1;
  localparam int RATE2_HZ   = 10;
  localparam int RATE3_HZ   = 25;
  localparam int RATE4_HZ   = 50;
  localparam int RATE5_HZ   = 75;
  localparam int PERIOD1_CYC = CLK_HZ / RATE1_HZ;
  localparam int PERIOD2_CYC = CLK_HZ / RATE2_HZ;
  localparam int PERIOD3_CYC = CLK_HZ / RATE3_HZ;
  localparam int PERIOD4_CYC = CLK_HZ / RATE4_HZ;
  localparam int PERIOD5_CYC = CLK_HZ / RATE5_HZ;
  localparam int PERIOD_W    = 25;

  // Low-pass filter smoothing shifts
  localparam int FILT_SHIFT_NARROW = 4;
  localparam int FILT_SHIFT_WIDE   = 3;

  typedef enum {
    ACQ_IDLE,
    ACQ_CONVERT,
    ACQ_FILTER
  } pac_acq_state_type;

endpackage : pac_pkg

//--- pac_rate_timer.sv
/*
  Acquisition period timer: emits a one-cycle tick per output period.
  Assumes the selected rate code is held in a register of the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_rate_timer #(
  parameter int P1 = pac_pkg::PERIOD1_CYC,
  parameter int P2 = pac_pkg::PERIOD2_CYC,
  parameter int P3 = pac_pkg::PERIOD3_CYC,
  parameter int P4 = pac_pkg::PERIOD4_CYC,
  parameter int P5 = pac_pkg::PERIOD5_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] rateSel,
  output logic            tick
);
  import pac_pkg::*;

  logic [PERIOD_W-1:0] count_ff;
  logic [2:0]          activeRate_ff;
  logic [PERIOD_W-1:0] reloadVal;
  logic                wrap;

  // Period lookup for the rate now requested
  assign reloadVal = (rateSel == 3'h1) ? PERIOD_W'(P1 - 1) :
                     (rateSel == 3'h2) ? PERIOD_W'(P2 - 1) :
                     (rateSel == 3'h3) ? PERIOD_W'(P3 - 1) :
                     (rateSel == 3'h4) ? PERIOD_W'(P4 - 1) :
                     PERIOD_W'(P5 - 1);
  // Leaving power-down starts at once; otherwise wait for period end
  assign wrap = (count_ff == '0) || (activeRate_ff == RATE_OFF);
  assign tick = wrap && (rateSel != RATE_OFF);

  // Rate is resampled only at a period boundary
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_ff      <= '0;
      activeRate_ff <= RATE_OFF;
    end else if (wrap) begin
      count_ff      <= reloadVal;
      activeRate_ff <= rateSel;
    end else begin
      count_ff      <= count_ff - PERIOD_W'(1);
    end
  end

endmodule : pac_rate_timer
`default_nettype wire

//--- pac_press_filter.sv
/*
  First-order low-pass on pressure samples, with a restart input.
  Assumes one sampleValid pulse per raw sample; result one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_press_filter #(
  parameter int W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         filterEn,
  input  wire logic         bandSel,
  input  wire logic         restart,
  input  wire logic         sampleValid,
  input  wire logic [W-1:0] sampleIn,
  output logic              outValid,
  output logic [W-1:0]      filtered
);
  import pac_pkg::*;

  logic signed [W-1:0] acc_ff;
  logic                primed_ff;
  logic                outValid_ff;
  logic signed [W:0]   diff;
  logic signed [W:0]   step;
  logic [W-1:0]        nxt_acc;

  // Narrower band smooths harder; disabled filter passes through
  assign diff = {sampleIn[W-1], sampleIn} - {acc_ff[W-1], acc_ff};
  assign step = bandSel ? (diff >>> FILT_SHIFT_NARROW)
                        : (diff >>> FILT_SHIFT_WIDE);
  // A restart in the sample's own cycle still drops the old history
  assign nxt_acc = (!filterEn || !primed_ff || restart) ? sampleIn
                 : W'(acc_ff + step[W-1:0]);
  assign outValid = outValid_ff;
  assign filtered = acc_ff;

  // Restart drops history so the next sample skips settling
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff      <= '0;
      primed_ff   <= 1'b0;
      outValid_ff <= 1'b0;
    end else begin
      outValid_ff <= sampleValid;
      if (sampleValid) begin
        acc_ff    <= nxt_acc;
        primed_ff <= 1'b1;
      end else if (restart) begin
        primed_ff <= 1'b0;
      end
    end
  end

endmodule : pac_press_filter
`default_nettype wire

//--- pac_control.sv
/*
  Pressure acquisition control: control registers, acquisition sequencing,
  offset subtraction, output locking and the register byte port.
  Assumes a serial protocol engine on core_clk delivering byte strobes, a
  conversion front end with start/done handshake, and a trim memory loader.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_control #(
  parameter int PERIOD1 = pac_pkg::PERIOD1_CYC,
  parameter int PERIOD2 = pac_pkg::PERIOD2_CYC,
  parameter int PERIOD3 = pac_pkg::PERIOD3_CYC,
  parameter int PERIOD4 = pac_pkg::PERIOD4_CYC,
  parameter int PERIOD5 = pac_pkg::PERIOD5_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        subAddrLoad,
  input  wire logic [6:0]  subAddr,
  input  wire logic        byteWr,
  input  wire logic [7:0]  wrData,
  input  wire logic        byteRd,
  output logic [7:0]       rdData,
  output logic             convStart,
  input  wire logic        convDone,
  input  wire logic [23:0] rawPressure,
  input  wire logic [15:0] rawTemperature,
  output logic             trimLoadReq,
  input  wire logic        trimLoadDone,
  output logic             newSample
);
  import pac_pkg::*;

  // Register state
  logic [7:0]  acqCtrl_ff;
  logic        reboot_ff;
  logic        autoInc_ff;
  logic        softReset_ff;
  logic        oneShot_ff;
  logic [15:0] offset_ff;
  logic [6:0]  addr_ff;
  logic [7:0]  rdData_ff;
  logic [23:0] pressOut_ff;
  logic [15:0] tempOut_ff;
  logic [23:0] pressPend_ff;
  logic [15:0] tempPend_ff;
  logic        pending_ff;
  logic        lock_ff;
  logic        convStart_ff;
  logic        trimLoadReq_ff;
  logic        trimReady_ff;
  logic        newSample_ff;
  logic [15:0] tempHold_ff;
  pac_acq_state_type state_ff;

  // Decoded control fields
  logic [2:0] rateSel;
  logic       filtEn;
  logic       filtBw;
  logic       lockEn;
  logic       powerDown;
  assign rateSel   = acqCtrl_ff[RATE_LSB +: 3];
  assign filtEn    = acqCtrl_ff[FILT_EN_BIT];
  assign filtBw    = acqCtrl_ff[FILT_BW_BIT];
  assign lockEn    = acqCtrl_ff[LOCK_BIT];
  assign powerDown = (rateSel == RATE_OFF);

  // Write and read decode on the current register address
  logic wrAcq;
  logic wrSys;
  logic wrOffLo;
  logic wrOffHi;
  logic rdPressH;
  logic rdOutByte;
  logic rdFiltRst;
  assign wrAcq     = byteWr && (addr_ff == ADDR_ACQ_CTRL);
  assign wrSys     = byteWr && (addr_ff == ADDR_SYS_CTRL);
  assign wrOffLo   = byteWr && (addr_ff == ADDR_OFFSET_LO);
  assign wrOffHi   = byteWr && (addr_ff == ADDR_OFFSET_HI);
  assign rdPressH  = byteRd && (addr_ff == ADDR_PRESS_H);
  assign rdOutByte = byteRd && (addr_ff >= ADDR_PRESS_XL)
                            && (addr_ff <= ADDR_TEMP_H);
  assign rdFiltRst = byteRd && (addr_ff == ADDR_FILTER_RST);

  // Register address pointer; advance per byte only with auto-increment
  logic       byteDone;
  logic [6:0] nxt_addr;
  assign byteDone = byteWr || byteRd;
  assign nxt_addr = subAddrLoad ? subAddr
                  : (byteDone && autoInc_ff) ? addr_ff + 7'h01
                  : addr_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      addr_ff <= '0;
    else
      addr_ff <= nxt_addr;
  end

  // Period tick for continuous acquisition
  logic rateTick;
  pac_rate_timer #(
    .P1 (PERIOD1),
    .P2 (PERIOD2),
    .P3 (PERIOD3),
    .P4 (PERIOD4),
    .P5 (PERIOD5)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .rateSel  (rateSel),
    .tick     (rateTick)
  );

  // Control registers; soft reset restores acquisition control and auto-increment on the following cycle, but not the reboot bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acqCtrl_ff   <= ACQ_CTRL_RESET;
      autoInc_ff   <= SYS_CTRL_RESET[AUTOINC_BIT];
      softReset_ff <= SYS_CTRL_RESET[SOFTRST_BIT];
    end else if (softReset_ff) begin
      acqCtrl_ff   <= ACQ_CTRL_RESET;
      autoInc_ff   <= SYS_CTRL_RESET[AUTOINC_BIT];
      softReset_ff <= 1'b0;
    end else begin
      if (wrAcq)
        acqCtrl_ff <= wrData & 8'h7E;          // Unused bits kept at zero
      if (wrSys) begin
        autoInc_ff   <= wrData[AUTOINC_BIT];
        softReset_ff <= wrData[SOFTRST_BIT];
      end
    end
  end

  // One-shot request; accepted only in power-down, cleared on completion
  logic sampleDone;
  logic oneShotSet;
  assign oneShotSet = wrSys && wrData[ONESHOT_BIT] && powerDown;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      oneShot_ff <= SYS_CTRL_RESET[ONESHOT_BIT];
    else if (oneShotSet)
      oneShot_ff <= 1'b1;
    else if (softReset_ff || (sampleDone && oneShot_ff))
      oneShot_ff <= 1'b0;
  end

  // Offset registers are not touched by soft reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      offset_ff <= OFFSET_RESET;
    end else begin
      if (wrOffLo)
        offset_ff[7:0] <= wrData;
      if (wrOffHi)
        offset_ff[15:8] <= wrData;
    end
  end

  // Trim load: requested out of reset and on reboot, held until done
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trimLoadReq_ff <= 1'b1;
      trimReady_ff   <= 1'b0;
      reboot_ff      <= 1'b0;
    end else if (trimLoadReq_ff) begin
      if (trimLoadDone) begin
        trimLoadReq_ff <= 1'b0;
        trimReady_ff   <= 1'b1;
        // Set wins: a reboot written as the load ends runs once more
        reboot_ff      <= wrSys && wrData[REBOOT_BIT];
      end
    end else if (wrSys && wrData[REBOOT_BIT]) begin
      reboot_ff <= 1'b1;
    end else if (reboot_ff && (rateTick || powerDown)) begin
      trimLoadReq_ff <= 1'b1;    // Reload lands on a period boundary, or at once in power-down
    end
  end

  // Acquisition sequencer; nothing runs before trims are loaded
  logic startAcq;
  logic filtValid;
  logic [23:0] filtPress;
  assign startAcq = trimReady_ff && !trimLoadReq_ff &&
                    ((rateTick && !powerDown) ||
                     (oneShot_ff && powerDown));
  assign sampleDone = (state_ff == ACQ_FILTER) && filtValid;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= ACQ_IDLE;
      convStart_ff <= 1'b0;
      tempHold_ff  <= '0;
    end else begin
      convStart_ff <= 1'b0;
      case (state_ff)
        ACQ_IDLE: begin
          if (startAcq) begin
            convStart_ff <= 1'b1;
            state_ff     <= ACQ_CONVERT;
          end
        end
        ACQ_CONVERT: begin
          if (convDone) begin
            tempHold_ff <= rawTemperature;
            state_ff    <= ACQ_FILTER;
          end
        end
        ACQ_FILTER: begin
          if (filtValid)
            state_ff <= ACQ_IDLE;
        end
        default: state_ff <= ACQ_IDLE;
      endcase
    end
  end

  pac_press_filter #(
    .W (24)
  ) u_filter (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .filterEn    (filtEn),
    .bandSel     (filtBw),
    .restart     (rdFiltRst),
    .sampleValid ((state_ff == ACQ_CONVERT) && convDone),
    .sampleIn    (rawPressure),
    .outValid    (filtValid),
    .filtered    (filtPress)
  );

  // Offset correction on every result
  logic [23:0] corrPress;
  assign corrPress = filtPress - {offset_ff, 8'h00};

  // Output registers with block-update lock
  logic lockedNow;
  logic unlockCopy;
  assign lockedNow  = lockEn && (lock_ff || rdOutByte) && !rdPressH;
  assign unlockCopy = pending_ff && !lockedNow;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pressOut_ff  <= '0;
      tempOut_ff   <= '0;
      pressPend_ff <= '0;
      tempPend_ff  <= '0;
      pending_ff   <= 1'b0;
      lock_ff      <= 1'b0;
    end else begin
      lock_ff <= lockedNow;
      if (sampleDone && lockedNow) begin
        pressPend_ff <= corrPress;
        tempPend_ff  <= tempHold_ff;
        pending_ff   <= 1'b1;
      end else if (sampleDone) begin
        pressOut_ff  <= corrPress;
        tempOut_ff   <= tempHold_ff;
        pending_ff   <= 1'b0;
      end else if (unlockCopy) begin
        pressOut_ff  <= pressPend_ff;
        tempOut_ff   <= tempPend_ff;
        pending_ff   <= 1'b0;
      end
    end
  end
  // Outputs change only via sampleDone or the pending copy on unlock; power-down stops periodic samples, one-shots still run

  // Read data mux; unmapped addresses and filter reset read as zero
  logic [7:0] sysCtrlView;
  logic [7:0] rdMux;
  assign sysCtrlView = {reboot_ff, 2'b00, autoInc_ff, 1'b0,
                        softReset_ff, 1'b0, oneShot_ff};
  assign rdMux = (addr_ff == ADDR_ACQ_CTRL)  ? acqCtrl_ff :
                 (addr_ff == ADDR_SYS_CTRL)  ? sysCtrlView :
                 (addr_ff == ADDR_OFFSET_LO) ? offset_ff[7:0] :
                 (addr_ff == ADDR_OFFSET_HI) ? offset_ff[15:8] :
                 (addr_ff == ADDR_PRESS_XL)  ? pressOut_ff[7:0] :
                 (addr_ff == ADDR_PRESS_L)   ? pressOut_ff[15:8] :
                 (addr_ff == ADDR_PRESS_H)   ? pressOut_ff[23:16] :
                 (addr_ff == ADDR_TEMP_L)    ? tempOut_ff[7:0] :
                 (addr_ff == ADDR_TEMP_H)    ? tempOut_ff[15:8] :
                 8'h00;

  // Read byte captured on the read strobe, held until the next one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rdData_ff <= 8'h00;
    else if (byteRd)
      rdData_ff <= rdMux;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      newSample_ff <= 1'b0;
    else
      newSample_ff <= sampleDone;
  end

  assign rdData      = rdData_ff;
  assign convStart   = convStart_ff;
  assign trimLoadReq = trimLoadReq_ff;
  assign newSample   = newSample_ff;

endmodule : pac_control
`default_nettype wire

//--- pac_control_chk.sv
/*
  Port assertions for pac_control.
  Bound to every pac_control instance; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_control_chk
  import pac_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        subAddrLoad,
  input wire logic [6:0]  subAddr,
  input wire logic        byteWr,
  input wire logic [7:0]  wrData,
  input wire logic        byteRd,
  input wire logic [7:0]  rdData,
  input wire logic        convStart,
  input wire logic        convDone,
  input wire logic [23:0] rawPressure,
  input wire logic [15:0] rawTemperature,
  input wire logic        trimLoadReq,
  input wire logic        trimLoadDone,
  input wire logic        newSample
);
  logic busy_ff;
  logic wrSeen_ff;
  logic booted_ff;

  // Conversion in flight, any host write, first trim load done
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_ff   <= 1'b0;
      wrSeen_ff <= 1'b0;
      booted_ff <= 1'b0;
    end else begin
      busy_ff   <= convStart | (busy_ff & ~convDone);
      wrSeen_ff <= wrSeen_ff | byteWr;
      booted_ff <= booted_ff | trimLoadDone;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Conversion link
  property p_start_pulse; convStart |=> !convStart; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("convStart held past one cycle");
  property p_trim_first; !booted_ff |-> !convStart; endproperty
  a_trim_first: assert property (p_trim_first)
    else $error("conversion before trim load");
  property p_done_sample;
    convDone && busy_ff |-> ##[2:3] newSample;
  endproperty
  a_done_sample: assert property (p_done_sample)
    else $error("no newSample after convDone");
  property p_sample_cause;
    newSample |-> $past(convDone, 2) || $past(convDone, 3);
  endproperty
  a_sample_cause: assert property (p_sample_cause)
    else $error("newSample without conversion");

  // Trim load request held until its answer
  property p_trim_hold;
    trimLoadReq && !trimLoadDone |=> trimLoadReq;
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim request dropped early");
  property p_trim_drop; $fell(trimLoadReq) |-> $past(trimLoadDone); endproperty
  a_trim_drop: assert property (p_trim_drop)
    else $error("trim request fell without done");

  // Register port answers
  property p_filt_rd;
    subAddrLoad && subAddr == ADDR_FILTER_RST ##1 byteRd |=> rdData == 8'h00;
  endproperty
  a_filt_rd: assert property (p_filt_rd)
    else $error("filter reset read not zero");
  property p_reset_val;
    !wrSeen_ff && subAddrLoad && subAddr == ADDR_SYS_CTRL ##1 byteRd
      |=> rdData == SYS_CTRL_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("system control reset value wrong");
  property p_rd_hold; !byteRd |=> $stable(rdData); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("rdData moved without a read");

  c_sample: cover property (newSample);
  c_reboot: cover property ($fell(trimLoadReq) && booted_ff);
  c_filt: cover property (subAddrLoad && subAddr == ADDR_FILTER_RST);
endmodule : pac_control_chk

bind pac_control pac_control_chk u_chk (
  .core_clk(core_clk), .rstn(rstn), .subAddrLoad(subAddrLoad),
  .subAddr(subAddr), .byteWr(byteWr), .wrData(wrData), .byteRd(byteRd),
  .rdData(rdData), .convStart(convStart), .convDone(convDone),
  .rawPressure(rawPressure), .rawTemperature(rawTemperature),
  .trimLoadReq(trimLoadReq), .trimLoadDone(trimLoadDone),
  .newSample(newSample)
);
`default_nettype wire

//--- pac_front_model.sv
/*
  Conversion front end and trim loader model.
  Assumes pac_control requests change just after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pac_front_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        convStart,
  input  wire logic        trimLoadReq,
  input  wire logic        slow,
  output logic             convDone,
  output logic [23:0]      rawPressure,
  output logic [15:0]      rawTemperature,
  output logic             trimLoadDone
);
  logic [7:0] seq_ff;
  logic [5:0] wait_ff;
  logic       busy_ff;
  logic [4:0] tWait_ff;

  // Data toggles outside its valid cycle so stale values never pass
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seq_ff         <= 8'h00;
      wait_ff        <= 6'h00;
      busy_ff        <= 1'b0;
      convDone       <= 1'b0;
      rawPressure    <= 24'h00_0000;
      rawTemperature <= 16'h0000;
    end else begin
      convDone       <= 1'b0;
      rawPressure    <= ~rawPressure;
      rawTemperature <= ~rawTemperature;
      if (convStart) begin
        busy_ff <= 1'b1;
        wait_ff <= slow ? 6'h28 : 6'h09;
      end else if (busy_ff && wait_ff == 6'h00) begin
        busy_ff        <= 1'b0;
        convDone       <= 1'b1;
        rawPressure    <= {8'h3A, seq_ff, ~seq_ff};
        rawTemperature <= {seq_ff, 8'hC3};
        seq_ff         <= seq_ff + 8'h01;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 6'h01;
      end
    end
  end

  // Trim load answers once per request, after a fixed delay
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tWait_ff     <= 5'h00;
      trimLoadDone <= 1'b0;
    end else begin
      trimLoadDone <= trimLoadReq && tWait_ff == 5'h13;
      if (!trimLoadReq) tWait_ff <= 5'h00;
      else if (tWait_ff != 5'h1F) tWait_ff <= tWait_ff + 5'h01;
    end
  end
endmodule : pac_front_model
`default_nettype wire

//--- tb_pressure_acquisition_control.sv
/*
  Self-checking bench for pac_control and the front end model.
  Assumes the byte-strobe register port of the protocol engine.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_pressure_acquisition_control;
  import pac_pkg::*;
  localparam int PER [1:5] = '{150, 130, 110, 90, 70};
  localparam logic [23:0] OFF = 24'h12_3400;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        subAddrLoad = 1'b0;
  logic [6:0]  subAddr = 7'h00;
  logic        byteWr = 1'b0;
  logic [7:0]  wrData = 8'h00;
  logic        byteRd = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rdData, d;
  logic        convStart, convDone, trimLoadReq, trimLoadDone, newSample;
  logic [23:0] rawPressure, lastP, v, e, p0;
  logic [15:0] rawTemperature, lastT;
  int          n_errors = 0, n_checks = 0, cyc = 0, nSamp = 0, stamp = 0;
  int          t0, t1;

  pac_control #(.PERIOD1(PER[1]), .PERIOD2(PER[2]), .PERIOD3(PER[3]),
    .PERIOD4(PER[4]), .PERIOD5(PER[5])) dut (
    .core_clk(core_clk), .rstn(rstn), .subAddrLoad(subAddrLoad),
    .subAddr(subAddr), .byteWr(byteWr), .wrData(wrData), .byteRd(byteRd),
    .rdData(rdData), .convStart(convStart), .convDone(convDone),
    .rawPressure(rawPressure), .rawTemperature(rawTemperature),
    .trimLoadReq(trimLoadReq), .trimLoadDone(trimLoadDone),
    .newSample(newSample));
  pac_front_model u_front (
    .core_clk(core_clk), .rstn(rstn), .convStart(convStart),
    .trimLoadReq(trimLoadReq), .slow(slow), .convDone(convDone),
    .rawPressure(rawPressure), .rawTemperature(rawTemperature),
    .trimLoadDone(trimLoadDone));

  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Raw sample capture, sample stamps and the hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (convDone === 1'b1) begin
      lastP = rawPressure;
      lastT = rawTemperature;
    end
    if (newSample === 1'b1) begin
      nSamp++;
      stamp = cyc;
    end
    if (cyc == 10000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // Bus tasks start and end at a falling edge
  task automatic setA(input logic [6:0] a);
    subAddr = a;
    subAddrLoad = 1'b1;
    @(negedge core_clk);
    subAddrLoad = 1'b0;
  endtask : setA
  task automatic rd(output logic [7:0] b);
    byteRd = 1'b1;
    @(negedge core_clk);
    byteRd = 1'b0;
    b = rdData;
    @(negedge core_clk);
  endtask : rd
  task automatic wr(input logic [7:0] b);
    wrData = b;
    byteWr = 1'b1;
    @(negedge core_clk);
    byteWr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic wrReg(input logic [6:0] a, input logic [7:0] b);
    setA(a);
    wr(b);
  endtask : wrReg
  task automatic chkReg(input logic [6:0] a, input logic [7:0] x);
    logic [7:0] b;
    setA(a);
    rd(b);
    `CHK(b, x)
  endtask : chkReg
  task automatic rd3(input logic [6:0] a, output logic [23:0] r);
    logic [7:0] b0, b1, b2;
    setA(a);
    rd(b0);
    rd(b1);
    rd(b2);
    r = {b2, b1, b0};
  endtask : rd3
  // Bounded waits on the design's own signals
  task automatic waitNs(output int t);
    int n0;
    int k;
    n0 = nSamp;
    k = 0;
    while (nSamp == n0 && k < 1000) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(k < 1000, 1'b1)
    t = stamp;
  endtask : waitNs
  task automatic waitTrim();
    int k;
    k = 0;
    while (trimLoadReq !== 1'b0 && k < 400) begin
      @(negedge core_clk);
      k++;
    end
  endtask : waitTrim

  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    waitTrim();
    `CHK(trimLoadReq, 1'b0)
    chkReg(ADDR_SYS_CTRL, SYS_CTRL_RESET);
    chkReg(ADDR_ACQ_CTRL, ACQ_CTRL_RESET);
    chkReg(ADDR_OFFSET_HI, 8'h00);
    chkReg(ADDR_FILTER_RST, 8'h00);
    setA(ADDR_OFFSET_LO);
    wr(8'h34);
    wr(8'h12);
    chkReg(ADDR_OFFSET_HI, 8'h12);
    chkReg(ADDR_OFFSET_LO, 8'h34);
    // One-shot with a slow front end, then power-down stays quiet
    slow = 1'b1;
    wrReg(ADDR_SYS_CTRL, 8'h11);
    waitNs(t0);
    e = lastP - OFF;
    rd3(ADDR_PRESS_XL, v);
    `CHK(v, e)
    rd(d);
    `CHK(d, lastT[7:0])
    rd(d);
    `CHK(d, lastT[15:8])
    chkReg(ADDR_SYS_CTRL, 8'h10);
    t1 = nSamp;
    repeat (400) @(negedge core_clk);
    `CHK(nSamp, t1)
    wrReg(ADDR_SYS_CTRL, 8'h00);
    setA(ADDR_PRESS_H);
    rd(d);
    rd(d);
    `CHK(d, e[23:16])
    wrReg(ADDR_SYS_CTRL, 8'h10);
    // Rate codes 1 to 5, period measured between later samples
    slow = 1'b0;
    for (int r = 1; r <= 5; r++) begin
      wrReg(ADDR_ACQ_CTRL, {1'b0, r[2:0], 4'h0});
      waitNs(t0);
      waitNs(t0);
      waitNs(t1);
      `CHK(t1 - t0, PER[r])
    end
    wrReg(ADDR_SYS_CTRL, 8'h11);
    chkReg(ADDR_SYS_CTRL, 8'h10);
    waitNs(t0);
    waitNs(t1);
    `CHK(t1 - t0, PER[5])
    // Locked read spanning two new samples
    wrReg(ADDR_ACQ_CTRL, 8'h52);
    waitNs(t0);
    e = lastP - OFF;
    setA(ADDR_PRESS_XL);
    rd(d);
    `CHK(d, e[7:0])
    waitNs(t0);
    waitNs(t0);
    rd(d);
    `CHK(d, e[15:8])
    rd(d);
    `CHK(d, e[23:16])
    rd3(ADDR_PRESS_XL, v);
    `CHK(v, lastP - OFF)
    // Power-down keeps the last result
    waitNs(t0);
    wrReg(ADDR_ACQ_CTRL, 8'h00);
    repeat (200) @(negedge core_clk);
    rd3(ADDR_PRESS_XL, v);
    `CHK(v, lastP - OFF)
    wrReg(ADDR_ACQ_CTRL, 8'h0C);
    chkReg(ADDR_ACQ_CTRL, 8'h0C);
    // Filter restart, then one filtered one-shot on the narrow band
    chkReg(ADDR_FILTER_RST, 8'h00);
    wrReg(ADDR_SYS_CTRL, 8'h11);
    waitNs(t0);
    p0 = lastP;
    rd3(ADDR_PRESS_XL, v);
    `CHK(v, p0 - OFF)
    wrReg(ADDR_SYS_CTRL, 8'h11);
    waitNs(t0);
    e = p0 + 24'(($signed({lastP[23], lastP}) - $signed({p0[23], p0}))
        >>> FILT_SHIFT_NARROW);
    rd3(ADDR_PRESS_XL, v);
    `CHK(v, e - OFF)
    // Soft reset, then reboot
    wrReg(ADDR_SYS_CTRL, 8'h04);
    chkReg(ADDR_ACQ_CTRL, ACQ_CTRL_RESET);
    chkReg(ADDR_SYS_CTRL, SYS_CTRL_RESET);
    wrReg(ADDR_SYS_CTRL, 8'h90);
    `CHK(trimLoadReq, 1'b1)
    waitTrim();
    chkReg(ADDR_SYS_CTRL, 8'h10);
    summarize();
  end
endmodule : tb_pressure_acquisition_control
`default_nettype wire
